// *** logic/mode_color_pkg.sv ***
package mode_color_pkg;
    // I/O port addresses of the two write-only registers
    localparam logic [9:0] MODE_ADDR = 10'h3d8;
    localparam logic [9:0] PALETTE_ADDR = 10'h3d9;
    // Field positions in the mode control register
    localparam int MODE_GFX_BIT = 1;
    localparam int MODE_ENABLE_BIT = 3;
    localparam int MODE_BLINK_BIT = 5;
    localparam int MODE_HIRES_BIT = 4;
    // Field positions in the colour select register
    localparam int PAL_INTENS_BIT = 4;
    localparam int PAL_SET_BIT = 5;
    // Reset values: video off, border black
    localparam logic [5:0] MODE_RESET = 6'h00;
    localparam logic [5:0] PALETTE_RESET = 6'h00;
    // Blink toggles every this many frame pulses
    localparam int BLINK_FRAMES = 16;
    // Values the host writes
    localparam logic [5:0] MODE_BLANK = 6'h00;
    localparam logic [5:0] MODE_TEXT40 = 6'h28;
    localparam logic [5:0] MODE_GFX_MR = 6'h2a;
    localparam logic [5:0] MODE_GFX_HR = 6'h1e;
    localparam logic [5:0] PAL_TEXT40 = 6'h30;
    // Expansion-bus write cycles held by the host
    localparam int WRITE_HOLD = 2;
endpackage : mode_color_pkg

// *** logic/io_write_if.sv ***
`timescale 1ns/100ps
interface io_write_if;
    // Expansion bus I/O write path (active low strobe)
    logic [9:0] addr;
    logic [7:0] data;
    logic iow_n;
    modport host (output addr, output data, output iow_n);
    modport device (input addr, input data, input iow_n);
endinterface : io_write_if

// *** logic/mode_color_dev.sv ***
`timescale 1ns/100ps
// Contract
// - Text mode, mode bit5 enables attribute blink
// - Graphics mode ignores mode bit5
// - Blink on limits background to eight colours
// - Mode below 20h gives intensified backgrounds
// - Host sets bit5 except hires graphics
// - Write to 3D9 sets border colour (text mode only; graphics border is forced to black)
// - Host programs black border for 40-column
// - Host programs black medium-res background
// - Host may rewrite palette later
// - Host blanks with 00-07 before mode change
// - Palette bits 0-3 give border/background/foreground
// - Palette bit5 picks cyan/magenta/white set (code gives magenta/brown/white)
// - Palette bit4 picks intensified set
module mode_color_dev (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Register write bus
    io_write_if.device BUS,
    // Pixel source: text attribute or graphics pixel
    input wire logic [7:0] ATTR,
    input wire logic [1:0] PIX2,
    input wire logic PIX1,
    input wire logic FG_ON,
    input wire logic BORDER,
    input wire logic FRAME,
    // Register views and colour out (IRGB)
    output logic [5:0] MODE_Q,
    output logic [5:0] PAL_Q,
    output logic VIDEO_ON,
    output logic [3:0] IRGB
);
    logic [5:0] mode_r;      // Mode control
    logic [5:0] pal_r;       // Colour select
    logic iow_d1_r, iow_d2_r, iow_d3_r;  // Strobe synchroniser and edge
    logic [9:0] addr_d1_r, addr_d2_r;
    logic [7:0] data_d1_r, data_d2_r;
    logic [4:0] blink_cnt_r; // Frame counter for blink phase
    logic blink_ph_r;
    logic [3:0] irgb_r;
    logic [3:0] irgb_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Bus pins come from another domain, so two flops first
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            iow_d1_r <= 1'b1;
            iow_d2_r <= 1'b1;
            iow_d3_r <= 1'b1;
            addr_d1_r <= 10'h000;
            addr_d2_r <= 10'h000;
            data_d1_r <= 8'h00;
            data_d2_r <= 8'h00;
        end else begin
            iow_d1_r <= BUS.iow_n;
            iow_d2_r <= iow_d1_r;
            iow_d3_r <= iow_d2_r;
            addr_d1_r <= BUS.addr;
            addr_d2_r <= addr_d1_r;
            data_d1_r <= BUS.data;
            data_d2_r <= data_d1_r;
        end
    end

    // Write takes effect on the rising edge of the strobe, data settled
    wire wr_end = iow_d2_r && !iow_d3_r;
    wire wr_mode = wr_end && (addr_d2_r == mode_color_pkg::MODE_ADDR);
    wire wr_pal = wr_end && (addr_d2_r == mode_color_pkg::PALETTE_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // Register file, only low six bits stored
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            mode_r <= mode_color_pkg::MODE_RESET;
            pal_r <= mode_color_pkg::PALETTE_RESET;
        end else begin
            if (wr_mode) begin
                mode_r <= data_d2_r[5:0];
            end
            if (wr_pal) begin
                pal_r <= data_d2_r[5:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Blink phase from frame pulses
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            blink_cnt_r <= 5'h00;
            blink_ph_r <= 1'b0;
        end else if (FRAME) begin
            if (blink_cnt_r == 5'(mode_color_pkg::BLINK_FRAMES - 1)) begin
                blink_cnt_r <= 5'h00;
                blink_ph_r <= !blink_ph_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 5'h01;
            end
        end
    end

    // Decoded mode and palette fields
    wire gfx = mode_r[mode_color_pkg::MODE_GFX_BIT];
    wire hires = mode_r[mode_color_pkg::MODE_HIRES_BIT];
    wire blink_en = mode_r[mode_color_pkg::MODE_BLINK_BIT];
    wire vid_en = mode_r[mode_color_pkg::MODE_ENABLE_BIT];
    wire [3:0] pal_col = pal_r[3:0];
    wire pal_int = pal_r[mode_color_pkg::PAL_INTENS_BIT];
    wire pal_set = pal_r[mode_color_pkg::PAL_SET_BIT];
    // Text background: top attribute bit is blink or intensity
    wire [3:0] txt_bg = blink_en ? {1'b0, ATTR[6:4]} : ATTR[7:4];
    wire txt_hide = blink_en && ATTR[7] && blink_ph_r;
    wire [3:0] txt_fg = txt_hide ? txt_bg : ATTR[3:0];

    ////////////////////////////////////////////////////////////////////////
    // Colour mux; graphics paths never read mode bit5
    always_comb begin
        irgb_nxt = 4'h0;
        if (!vid_en) begin
            irgb_nxt = 4'h0;
        end else if (BORDER) begin
            irgb_nxt = gfx ? 4'h0 : pal_col;
        end else if (!gfx) begin
            irgb_nxt = FG_ON ? txt_fg : txt_bg;
        end else if (hires) begin
            irgb_nxt = PIX1 ? pal_col : 4'h0;
        end else if (PIX2 == 2'b00) begin
            irgb_nxt = pal_col;
        end else begin
            // Blue/green/cyan or magenta/brown/white, optional intensity
            irgb_nxt = {pal_int, pal_set, PIX2};
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            irgb_r <= 4'h0;
        end else begin
            irgb_r <= irgb_nxt;
        end
    end

    assign MODE_Q = mode_r;
    assign PAL_Q = pal_r;
    assign VIDEO_ON = vid_en;
    assign IRGB = irgb_r;
endmodule : mode_color_dev

// *** logic/mode_color_host.sv ***
`timescale 1ns/100ps
module mode_color_host (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Register write bus
    io_write_if.host BUS,
    // Command: 0 text40, 1 medium graphics, 2 hires, 3 palette rewrite
    input wire logic REQ,
    input wire logic [1:0] CMD,
    input wire logic [5:0] PAL_VAL,
    output logic BUSY
);
    typedef enum logic [3:0] {
        IDLE = 4'b0001, BLANK = 4'b0010, SETMODE = 4'b0100, SETPAL = 4'b1000
    } hst_t;
    hst_t st_r;
    logic [1:0] cmd_r;
    logic [5:0] pal_r;
    logic [2:0] cyc_r;   // Cycle within one write
    logic [9:0] addr_r;
    logic [7:0] data_r;
    logic iow_n_r;
    logic busy_r;        // Sequence in progress, kept as a flop for a clean output

    // Mode value per command; bit5 set except hires
    wire [5:0] mode_val = (cmd_r == 2'd2) ? mode_color_pkg::MODE_GFX_HR :
                          (cmd_r == 2'd1) ? mode_color_pkg::MODE_GFX_MR :
                          mode_color_pkg::MODE_TEXT40;
    // Palette: text40 black border, medium graphics black background
    wire [5:0] pal_val = (cmd_r == 2'd3) ? pal_r :
                         mode_color_pkg::PAL_TEXT40;
    wire done = cyc_r == 3'(2 * mode_color_pkg::WRITE_HOLD);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: blank (00-07) first, then mode, then palette; command 3 writes the palette only
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            st_r <= IDLE;
            cmd_r <= 2'd0;
            pal_r <= 6'h00;
            cyc_r <= 3'h0;
            addr_r <= 10'h000;
            data_r <= 8'h00;
            iow_n_r <= 1'b1;
            busy_r <= 1'b0;
        end else begin
            case (st_r)
                IDLE: begin
                    iow_n_r <= 1'b1;
                    cyc_r <= 3'h0;
                    if (REQ) begin
                        cmd_r <= CMD;
                        pal_r <= PAL_VAL;
                        busy_r <= 1'b1;
                        st_r <= (CMD == 2'd3) ? SETPAL : BLANK;
                    end
                end
                default: begin
                    addr_r <= (st_r == SETPAL) ? mode_color_pkg::PALETTE_ADDR
                                               : mode_color_pkg::MODE_ADDR;
                    data_r <= {2'b00, (st_r == BLANK) ? mode_color_pkg::MODE_BLANK
                              : (st_r == SETMODE) ? mode_val : pal_val};
                    iow_n_r <= !(cyc_r < 3'(mode_color_pkg::WRITE_HOLD));
                    cyc_r <= cyc_r + 3'h1;
                    if (done) begin
                        cyc_r <= 3'h0;
                        case (st_r)
                            BLANK: st_r <= SETMODE;
                            SETMODE: st_r <= SETPAL;
                            default: begin
                                // Last write issued, accept the next request
                                st_r <= IDLE;
                                busy_r <= 1'b0;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    assign BUS.addr = addr_r;
    assign BUS.data = data_r;
    assign BUS.iow_n = iow_n_r;
    assign BUSY = busy_r;
endmodule : mode_color_host

// *** verif/mode_color_props.sv ***
`timescale 1ns/100ps
// Watches the write bus and the colour path of the device
module mode_color_props (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Write bus
    input wire logic [9:0] addr,
    input wire logic [7:0] data,
    input wire logic iow_n,
    // Device side
    input wire logic [5:0] MODE_Q,
    input wire logic [5:0] PAL_Q,
    input wire logic VIDEO_ON,
    input wire logic [3:0] IRGB,
    input wire logic [7:0] ATTR,
    input wire logic [1:0] PIX2,
    input wire logic FG_ON,
    input wire logic BORDER
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////
    // Background pixel in text mode, and active medium-res pixel
    wire logic txt = MODE_Q[3] && !MODE_Q[1] && !BORDER && !FG_ON;
    wire logic mr = MODE_Q[3] && MODE_Q[1] && !MODE_Q[4] && !BORDER;
    // Data holds until the next strobe, so depth 4 still sees it
    mode_write_a: assert property ($rose(iow_n) && addr == 10'h3d8
        |-> ##4 MODE_Q == $past(data[5:0], 4)) else $error("mode not loaded");
    pal_write_a: assert property ($rose(iow_n) && addr == 10'h3d9
        |-> ##4 PAL_Q == $past(data[5:0], 4)) else $error("palette not loaded");
    strobe_len_a: assert property ($fell(iow_n)
        |-> !iow_n ##1 !iow_n ##1 iow_n) else $error("strobe length");
    hold_still_a: assert property (iow_n [*6]
        |-> $stable(MODE_Q) && $stable(PAL_Q)) else $error("register moved");
    blank_out_a: assert property (!VIDEO_ON |=> IRGB == 4'h0)
        else $error("video not blanked");
    text_blink_a: assert property (txt && MODE_Q[5]
        |=> IRGB == {1'b0, $past(ATTR[6:4])}) else $error("text background");
    border_col_a: assert property (MODE_Q[3] && !MODE_Q[1] && BORDER
        |=> IRGB == $past(PAL_Q[3:0])) else $error("border colour");
    mr_back_a: assert property (mr && PIX2 == 2'b00
        |=> IRGB == $past(PAL_Q[3:0])) else $error("graphics background");
    mr_set_a: assert property (mr && PIX2 != 2'b00
        |=> IRGB == {$past(PAL_Q[4]), $past(PAL_Q[5]), $past(PIX2)})
        else $error("graphics colour set");
    // Main scenarios reached
    cover property (txt && MODE_Q[5]);
    cover property (mr && PIX2 == 2'b11);
    cover property ($rose(iow_n) && addr == 10'h3d9);
endmodule : mode_color_props

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    // Stimulus, design outputs and counters
    logic clk = 1'b0, nrst = 1'b0, req = 1'b0, pix1 = 1'b0;
    logic fg_on = 1'b0, border = 1'b0, frame = 1'b0, video_on, busy;
    logic [1:0] cmd = 2'h0, pix2 = 2'h0;
    logic [5:0] pal_val = 6'h00, mode_q, pal_q;
    logic [7:0] attr = 8'h00;
    logic [3:0] irgb;
    int error_cnt = 0, checks = 0, m_mode = 0, m_pal = 0, frames = 0;
    int seq[$] = '{0, 3, 1, 3, 2, 3};
    io_write_if bus();
    mode_color_host u_mode_color_host (.CLK(clk), .NRST(nrst), .BUS(bus),
        .REQ(req), .CMD(cmd), .PAL_VAL(pal_val), .BUSY(busy));
    mode_color_dev u_mode_color_dev (.CLK(clk), .NRST(nrst), .BUS(bus),
        .ATTR(attr), .PIX2(pix2), .PIX1(pix1), .FG_ON(fg_on), .BORDER(border),
        .FRAME(frame), .MODE_Q(mode_q), .PAL_Q(pal_q), .VIDEO_ON(video_on), .IRGB(irgb));
    mode_color_props u_mode_color_props (.CLK(clk), .NRST(nrst), .addr(bus.addr),
        .data(bus.data), .iow_n(bus.iow_n), .MODE_Q(mode_q), .PAL_Q(pal_q),
        .VIDEO_ON(video_on), .IRGB(irgb), .ATTR(attr), .PIX2(pix2), .FG_ON(fg_on),
        .BORDER(border));
    // Frame pulses seen out of reset, for the blink phase
    always @(posedge clk) begin
        if (nrst && frame) begin
            frames++;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Colour model; -1 where graphics border or hires background is open
    function automatic int colour(int m, int p, int a, int x2, int x1, int fg, int bd,
                                  int ph);
        if (m[3] == 0) return 0;
        if (m[1] == 0) begin
            if (bd != 0) return p & 15;
            if (fg != 0) return (m[5] && a[7] && ph != 0) ? (a >> 4) & 7 : a & 15;
            return m[5] ? (a >> 4) & 7 : (a >> 4) & 15;
        end
        if (bd != 0) return -1;
        if (m[4]) return x1 != 0 ? p & 15 : -1;
        return x2 == 0 ? p & 15 : (p[4] << 3) | (p[5] << 2) | x2;
    endfunction : colour
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    // Random pixel inputs, colour compared one cycle later
    task automatic sample(int n);
        int e;
        repeat (n) begin
            @(posedge clk);
            {attr, pix2, pix1, fg_on, border, frame} <= 14'($urandom);
            @(negedge clk);
            e = colour(m_mode, m_pal, attr, pix2, pix1, fg_on, border,
                       (frames / mode_color_pkg::BLINK_FRAMES) % 2);
            @(posedge clk);
            #1;
            if (e >= 0) check("irgb", 8'(irgb), 8'(e));
        end
    endtask : sample
    // One host command, with a stray request while busy
    task automatic run(int c);
        int t = 0;
        @(posedge clk);
        req <= 1'b1;
        cmd <= 2'(c);
        pal_val <= 6'($urandom);
        @(posedge clk);
        req <= 1'b0;
        repeat (4) @(posedge clk);
        req <= 1'b1;
        cmd <= 2'd2;
        @(posedge clk);
        req <= 1'b0;
        while (busy !== 1'b0 && t < 40) begin
            @(negedge clk);
            t++;
        end
        if (t == 40) error_cnt++;
        repeat (6) @(posedge clk);
        m_pal = c == 3 ? int'(pal_val) : 'h30;
        if (c != 3) m_mode = c == 0 ? 'h28 : c == 1 ? 'h2a : 'h1e;
        check("mode", 8'(mode_q), 8'(m_mode));
        check("palette", 8'(pal_q), 8'(m_pal));
        check("video", 8'(video_on), 8'((m_mode >> 3) & 1));
    endtask : run
    ////////////////////////////////////////////////////////////////
    initial forever #12.5 clk = ~clk;
    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h33fafb2e));
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        sample(20);
        foreach (seq[i]) begin
            run(seq[i]);
            sample(40);
        end
        give_verdict();
    end
endmodule : testbench
